// *** rtl/aild_top.sv ***
// Limit event, diagnostic and fault lamp logic with an Avalon-MM register slave
//
// Operation
// - A channel 0 result above its high limit sets bit 0 of detail byte 0.
// - A channel 2 result above its high limit sets bit 1 of detail byte 0.
// - A channel 0 result below its low limit sets bit 0 of detail byte 1.
// - A channel 2 result below its low limit sets bit 1 of detail byte 1.
// - A repeat of a still-pending limit cause sets the lost bit and a diagnostic event.
// - Overflow reports 7FFFh, underflow 8000h, with diagnostic entry, lamp and interrupt.
// - Nominal, overdrive and underdrive results pass unchanged with no side effect.
// - Overflow or underflow raises the diagnostic interrupt only when it is enabled.
// - Results outside the limits set their detail bits and raise the limit interrupt only when it is enabled.
// - Overflow or underflow lights the lamp and records an entry only with group diagnostics.
// - A missing external supply always lights the group fault lamp.
// - Only channels 0 and 2 can produce limit events.
// - Limit interrupts are disabled after reset.
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
module aild_top (
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [5:0]                    avs_address,
	input  wire logic [31:0]                   avs_writedata,
	output logic [31:0]                        avs_readdata,
	output logic                               avs_waitrequest,
	input  wire aild_pkg::aild_conv_t [1:0]    conv_in,
	input  wire logic                          supply_missing,
	output logic                               limit_irq,
	output logic                               diag_irq,
	output logic                               group_fault_lamp
);

	// Whole register state of the top level
	typedef struct packed {
		logic [2:0]                  ctrl;
		aild_pkg::aild_limits_t [1:0] lim;
		logic [1:0]                  det_hi;
		logic [1:0]                  det_lo;
		logic                        lost;
		logic [1:0]                  ovf_ent;
		logic [1:0]                  unf_ent;
		logic                        diag_pend;
		logic                        lamp;
		logic                        ack;
		logic [31:0]                 rdata;
	} aild_top_state_t;

	aild_top_state_t             q;
	aild_top_state_t             d;
	aild_pkg::aild_avs_req_t     req;
	aild_pkg::aild_chk_t [1:0]   chk;
	logic                        supply_sync;
	logic [3:0]                  idx;
	logic                        take_wr;
	logic [1:0]                  clr;
	logic [1:0]                  hi_evt;
	logic [1:0]                  lo_evt;
	logic                        lost_evt;
	logic                        diag_evt;
	logic [31:0]                 rmux;

	assign req.read      = avs_read;
	assign req.write     = avs_write;
	assign req.address   = avs_address;
	assign req.writedata = avs_writedata;
	assign idx           = req.address[5:2];

	// Supply status is a pin, so it is synchronised before use
	aild_sync2 u_supply_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (supply_missing),
		.sync_out (supply_sync)
	);

	// One checker per limit-capable input; no other channel exists
	for (genvar i = 0; i < aild_pkg::NUM_CH; i++) begin : g_ch
		aild_limit_chk u_chk (
			.sys_clk (sys_clk),
			.rst_n   (rst_n),
			.conv_i  (conv_in[i]),
			.lim_i   (q.lim[i]),
			.chk_o   (chk[i])
		);
	end

	// Read multiplexer; unmapped words read as zero
	always_comb begin
		rmux = 32'h0000_0000;
		case (idx)
			aild_pkg::IDX_CTRL: begin
				rmux[2:0] = q.ctrl;
			end
			aild_pkg::IDX_HI0: begin
				rmux[15:0] = q.lim[0].hi;
			end
			aild_pkg::IDX_LO0: begin
				rmux[15:0] = q.lim[0].lo;
			end
			aild_pkg::IDX_HI2: begin
				rmux[15:0] = q.lim[1].hi;
			end
			aild_pkg::IDX_LO2: begin
				rmux[15:0] = q.lim[1].lo;
			end
			aild_pkg::IDX_DETAIL: begin
				// Upper two bytes are reserved and stay zero
				rmux[aild_pkg::DET_HI_LSB +: 2] = q.det_hi;
				rmux[aild_pkg::DET_LO_LSB +: 2] = q.det_lo;
			end
			aild_pkg::IDX_DIAG: begin
				rmux[aild_pkg::DIAG_OVF_LSB +: 2] = q.ovf_ent;
				rmux[aild_pkg::DIAG_UNF_LSB +: 2] = q.unf_ent;
				rmux[aild_pkg::DIAG_SUPPLY]       = supply_sync;
				rmux[aild_pkg::DIAG_LOST_BIT]     = q.lost;
			end
			aild_pkg::IDX_RES0: begin
				rmux[15:0] = chk[0].value;
			end
			aild_pkg::IDX_RES2: begin
				rmux[15:0] = chk[1].value;
			end
			default: begin
				rmux = 32'h0000_0000;
			end
		endcase
	end

	// Event decode from the checkers; limit events gated by the limit enable, range faults ungated here
	always_comb begin
		take_wr = req.write & q.ack;
		clr     = 2'b00;
		if (take_wr && idx == aild_pkg::IDX_ACK) begin
			clr[0] = req.writedata[aild_pkg::ACK_LIMIT];
			clr[1] = req.writedata[aild_pkg::ACK_DIAG];
		end
		lost_evt = 1'b0;
		diag_evt = 1'b0;
		for (int i = 0; i < 2; i++) begin
			hi_evt[i] = chk[i].done & chk[i].above & q.ctrl[aild_pkg::CTRL_LIMIT_IRQ_EN];
			lo_evt[i] = chk[i].done & chk[i].below & q.ctrl[aild_pkg::CTRL_LIMIT_IRQ_EN];
			// Same cause still pending and not being acknowledged now
			if ((hi_evt[i] && q.det_hi[i] && !clr[0]) || (lo_evt[i] && q.det_lo[i] && !clr[0])) begin
				lost_evt = 1'b1;
			end
			if (chk[i].done && (chk[i].ovf || chk[i].unf)) begin
				diag_evt = 1'b1;
			end
		end
	end

	// Next-state logic: bus slave, event flags and lamp
	always_comb begin
		d     = q;
		// One wait cycle, then the request is taken with waitrequest low
		d.ack = (req.read | req.write) & ~q.ack;
		if (req.read && !q.ack) begin
			d.rdata = rmux;
		end
		if (take_wr) begin
			case (idx)
				aild_pkg::IDX_CTRL: begin
					d.ctrl = req.writedata[2:0];
				end
				aild_pkg::IDX_HI0: begin
					d.lim[0].hi = req.writedata[15:0];
				end
				aild_pkg::IDX_LO0: begin
					d.lim[0].lo = req.writedata[15:0];
				end
				aild_pkg::IDX_HI2: begin
					d.lim[1].hi = req.writedata[15:0];
				end
				aild_pkg::IDX_LO2: begin
					d.lim[1].lo = req.writedata[15:0];
				end
				default: begin
					d.ctrl = q.ctrl;
				end
			endcase
		end
		// Clears first, then sets, so a same-cycle event is never lost
		if (clr[0]) begin
			d.det_hi = 2'b00;
			d.det_lo = 2'b00;
		end
		if (clr[1]) begin
			d.lost      = 1'b0;
			d.diag_pend = 1'b0;
			d.ovf_ent   = 2'b00;
			d.unf_ent   = 2'b00;
		end
		d.det_hi[0] = d.det_hi[0] | hi_evt[0];
		d.det_hi[1] = d.det_hi[1] | hi_evt[1];
		d.det_lo[0] = d.det_lo[0] | lo_evt[0];
		d.det_lo[1] = d.det_lo[1] | lo_evt[1];
		if (lost_evt) begin
			d.lost      = 1'b1;
			d.diag_pend = 1'b1;
		end
		for (int i = 0; i < 2; i++) begin
			if (chk[i].done && q.ctrl[aild_pkg::CTRL_GROUP_DIAG_EN]) begin
				d.ovf_ent[i] = d.ovf_ent[i] | chk[i].ovf;
				d.unf_ent[i] = d.unf_ent[i] | chk[i].unf;
			end
		end
		if (diag_evt && q.ctrl[aild_pkg::CTRL_DIAG_IRQ_EN]) begin
			d.diag_pend = 1'b1;
		end
		// Supply loss overrides every enable
		d.lamp = supply_sync | (|(d.ovf_ent | d.unf_ent));
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q          <= '0;
			q.ctrl     <= aild_pkg::CTRL_RST;
			q.lim[0].hi <= aild_pkg::HI_RST;
			q.lim[0].lo <= aild_pkg::LO_RST;
			q.lim[1].hi <= aild_pkg::HI_RST;
			q.lim[1].lo <= aild_pkg::LO_RST;
		end else begin
			q <= d;
		end
	end

	// Outputs; waitrequest is combinational as the bus allows
	assign avs_waitrequest  = (req.read | req.write) & ~q.ack;
	assign avs_readdata     = q.rdata;
	assign limit_irq        = |{q.det_hi, q.det_lo};
	assign diag_irq         = q.diag_pend;
	assign group_fault_lamp = q.lamp;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	hi0_detail_a : assert property (
		chk[0].done && chk[0].above && q.ctrl[1] |=> q.det_hi[0] && limit_irq)
		else $error("channel 0 high event missed");

	hi2_detail_a : assert property (
		chk[1].done && chk[1].above && q.ctrl[1] |=> q.det_hi[1] && limit_irq)
		else $error("channel 2 high event missed");

	lo0_detail_a : assert property (
		chk[0].done && chk[0].below && q.ctrl[1] |=> q.det_lo[0])
		else $error("channel 0 low event missed");

	lo2_detail_a : assert property (
		chk[1].done && chk[1].below && q.ctrl[1] |=> q.det_lo[1])
		else $error("channel 2 low event missed");

	lost_flag_a : assert property (
		chk[0].done && chk[0].above && q.ctrl[1] && q.det_hi[0] && !clr[0]
		|=> q.lost && diag_irq)
		else $error("lost limit event not flagged");

	diag_gate_a : assert property (
		$rose(diag_irq) |-> $past(q.ctrl[0]) || q.lost)
		else $error("diagnostic interrupt while disabled");

	limit_gate_a : assert property (
		$rose(limit_irq) |-> $past(q.ctrl[1]))
		else $error("limit interrupt while disabled");

	entry_gate_a : assert property (
		$rose(|(q.ovf_ent | q.unf_ent)) |-> $past(q.ctrl[2]) && group_fault_lamp)
		else $error("diagnostic entry while group diagnostics off");

	supply_lamp_a : assert property (
		supply_sync [*2] |-> group_fault_lamp)
		else $error("lamp dark with supply missing");

	reserved_zero_a : assert property (
		avs_read && !avs_waitrequest && $past(idx) == 4'h5 |-> avs_readdata[31:16] == 16'h0000)
		else $error("reserved detail bytes not zero");

	// Further guards on the enables, the entries and the once-per-conversion compare
	// Overflow on channel 0 with group diagnostics must reach its entry and the lamp
	ovf_entry_a : assert property (
		chk[0].done && chk[0].ovf && q.ctrl[aild_pkg::CTRL_GROUP_DIAG_EN]
		|=> q.ovf_ent[0] && group_fault_lamp)
		else $error("overflow entry or lamp missing");

	// Underflow on channel 2 with group diagnostics must reach its entry and the lamp
	unf_entry_a : assert property (
		chk[1].done && chk[1].unf && q.ctrl[aild_pkg::CTRL_GROUP_DIAG_EN]
		|=> q.unf_ent[1] && group_fault_lamp)
		else $error("underflow entry or lamp missing");

	// An enabled range fault always raises the diagnostic interrupt, even against an ack
	diag_set_a : assert property (
		((chk[0].done && (chk[0].ovf || chk[0].unf))
		|| (chk[1].done && (chk[1].ovf || chk[1].unf)))
		&& q.ctrl[aild_pkg::CTRL_DIAG_IRQ_EN] |=> diag_irq)
		else $error("enabled diagnostic interrupt missed");

	// With group diagnostics off no entry may appear from nothing
	entry_off_a : assert property (
		!q.ctrl[aild_pkg::CTRL_GROUP_DIAG_EN] && q.ovf_ent == 2'b00 && q.unf_ent == 2'b00
		|=> q.ovf_ent == 2'b00 && q.unf_ent == 2'b00)
		else $error("entry recorded while group diagnostics off");

	// A quiet block stays quiet across an in-range result
	nominal_quiet_a : assert property (
		chk[0].done && !chk[0].ovf && !chk[0].unf && !chk[1].done && !lost_evt
		&& !q.diag_pend && !q.lamp && !supply_sync
		|=> !diag_irq && !group_fault_lamp)
		else $error("side effect from an in-range result");

	// No checker result without a conversion pulse on channel 0
	once_ch0_a : assert property (
		!conv_in[0].valid
		|=> !chk[0].done)
		else $error("channel 0 compared without a conversion");

	// No checker result without a conversion pulse on channel 2
	once_ch2_a : assert property (
		!conv_in[1].valid
		|=> !chk[1].done)
		else $error("channel 2 compared without a conversion");

	// Enables only move on a taken write to the control word
	ctrl_hold_a : assert property (
		!$stable(q.ctrl)
		|-> $past(take_wr) && $past(idx) == aild_pkg::IDX_CTRL)
		else $error("control changed without a write");

	// A repeated low event on channel 2 is also reported as lost
	lo_lost_a : assert property (
		chk[1].done && chk[1].below && q.ctrl[1] && q.det_lo[1] && !clr[0]
		|=> q.lost && diag_irq)
		else $error("lost low event not flagged");

	// An acknowledge without a fresh event empties the high flag
	det_clear_a : assert property (
		clr[0] && !hi_evt[0]
		|=> !q.det_hi[0])
		else $error("high flag survived acknowledge");

	// Supply status reads back as it stood in the wait cycle, one cycle before the read was taken
	supply_diag_a : assert property (
		$past(supply_sync) && $past(idx) == aild_pkg::IDX_DIAG && avs_read && !avs_waitrequest
		|-> avs_readdata[aild_pkg::DIAG_SUPPLY])
		else $error("supply status not reported");

endmodule

// *** rtl/aild_pkg.sv ***
// Shared constants and carrier types for the analog input limit diagnostics block
package aild_pkg;

	// Channel count: only the two limit-capable inputs exist
	localparam int unsigned NUM_CH = 2;

	// Register word indices; byte address is four times the index
	localparam logic [3:0] IDX_CTRL   = 4'h0;
	localparam logic [3:0] IDX_HI0    = 4'h1;
	localparam logic [3:0] IDX_LO0    = 4'h2;
	localparam logic [3:0] IDX_HI2    = 4'h3;
	localparam logic [3:0] IDX_LO2    = 4'h4;
	localparam logic [3:0] IDX_DETAIL = 4'h5;
	localparam logic [3:0] IDX_DIAG   = 4'h6;
	localparam logic [3:0] IDX_RES0   = 4'h7;
	localparam logic [3:0] IDX_RES2   = 4'h8;
	localparam logic [3:0] IDX_ACK    = 4'h9;

	// Control register bit positions
	localparam int unsigned CTRL_DIAG_IRQ_EN   = 0;
	localparam int unsigned CTRL_LIMIT_IRQ_EN  = 1;
	localparam int unsigned CTRL_GROUP_DIAG_EN = 2;

	// Acknowledge register bit positions (write one to clear)
	localparam int unsigned ACK_LIMIT = 0;
	localparam int unsigned ACK_DIAG  = 1;

	// Field positions in the event detail word and diagnostic word
	localparam int unsigned DET_HI_LSB    = 0;
	localparam int unsigned DET_LO_LSB    = 8;
	localparam int unsigned DIAG_OVF_LSB  = 0;
	localparam int unsigned DIAG_UNF_LSB  = 2;
	localparam int unsigned DIAG_SUPPLY   = 4;
	localparam int unsigned DIAG_LOST_BIT = 30;

	// Substitute codes and reset values
	localparam logic [15:0] CODE_OVF = 16'h7FFF;
	localparam logic [15:0] CODE_UNF = 16'h8000;
	localparam logic [15:0] HI_RST   = 16'h7FFF;
	localparam logic [15:0] LO_RST   = 16'h8000;
	localparam logic [2:0]  CTRL_RST = 3'h0;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [5:0]  address;
		logic [31:0] writedata;
	} aild_avs_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} aild_avs_rsp_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] value;
		logic        ovf;
		logic        unf;
	} aild_conv_t;

	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
	} aild_limits_t;

	typedef struct packed {
		logic [15:0] value;
		logic        above;
		logic        below;
		logic        ovf;
		logic        unf;
		logic        done;
	} aild_chk_t;

	typedef struct packed {
		logic s1;
		logic s2;
	} aild_sync_t;

endpackage

// *** rtl/aild_sync2.sv ***
// Two-flop synchroniser for one asynchronous level
module aild_sync2 (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic async_in,
	output logic      sync_out
);

	aild_pkg::aild_sync_t q;
	aild_pkg::aild_sync_t d;

	// First stage feeds only the second stage
	always_comb begin
		d.s1 = async_in;
		d.s2 = q.s1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.s2;

endmodule

// *** rtl/aild_limit_chk.sv ***
// Per-channel result substitution and limit comparison
module aild_limit_chk (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire aild_pkg::aild_conv_t conv_i,
	input  wire aild_pkg::aild_limits_t lim_i,
	output aild_pkg::aild_chk_t       chk_o
);

	aild_pkg::aild_chk_t q;
	aild_pkg::aild_chk_t d;

	// One compare per conversion; out-of-range codes skip the limit test
	always_comb begin
		d      = q;
		d.done = conv_i.valid;
		if (conv_i.valid) begin
			d.ovf   = conv_i.ovf;
			d.unf   = conv_i.unf & ~conv_i.ovf;
			d.above = 1'b0;
			d.below = 1'b0;
			if (conv_i.ovf) begin
				d.value = aild_pkg::CODE_OVF;
			end else if (conv_i.unf) begin
				d.value = aild_pkg::CODE_UNF;
			end else begin
				d.value = conv_i.value;
				d.above = $signed(conv_i.value) > $signed(lim_i.hi);
				d.below = $signed(conv_i.value) < $signed(lim_i.lo);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign chk_o = q;

	ovf_code_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
		conv_i.valid && conv_i.ovf |=> chk_o.value == 16'h7FFF && chk_o.done)
		else $error("overflow code not substituted");

	unf_code_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
		conv_i.valid && conv_i.unf && !conv_i.ovf |=> chk_o.value == 16'h8000)
		else $error("underflow code not substituted");

	value_pass_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
		conv_i.valid && !conv_i.ovf && !conv_i.unf
		|=> chk_o.value == $past(conv_i.value) && !chk_o.ovf && !chk_o.unf)
		else $error("nominal value altered");

endmodule

// *** tb/aild_cpu_model.sv ***
// Backplane CPU model: an Avalon-MM master with one bounded transfer task
module aild_cpu_model (
	input  wire logic        sys_clk,
	output logic             avs_read,
	output logic             avs_write,
	output logic [5:0]       avs_address,
	output logic [31:0]      avs_writedata,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus from time zero
	initial begin
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
	end

	// One word; the request holds until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
			output logic [31:0] rd, output bit ok);
		int n;
		ok = 1'b0;
		rd = 32'h0;
		@(posedge sys_clk);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= {idx, 2'h0};
		avs_writedata <= wd;
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge sys_clk);
			ok = (avs_waitrequest === 1'h0);
		end
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		avs_writedata <= ~wd; // Stale data must not look valid
	endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the limit diagnostics block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                       sys_clk = 1'h0;
	logic                       rst_n = 1'h0;
	logic                       avs_read;
	logic                       avs_write;
	logic                       avs_waitrequest;
	logic [5:0]                 avs_address;
	logic [31:0]                avs_writedata;
	logic [31:0]                avs_readdata;
	aild_pkg::aild_conv_t [1:0] conv_in = '0;
	logic                       supply_missing = 1'h0;
	logic                       limit_irq;
	logic                       diag_irq;
	logic                       group_fault_lamp;
	int                         errors = 0;
	int                         checks = 0;
	logic [31:0]                d;
	logic [15:0]                hi [2];
	logic [15:0]                lo [2];
	logic [15:0]                v [2];

	// 50 MHz clock
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

	aild_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read),
		.avs_write(avs_write), .avs_address(avs_address), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conv_in(conv_in),
		.supply_missing(supply_missing), .limit_irq(limit_irq), .diag_irq(diag_irq),
		.group_fault_lamp(group_fault_lamp));

	aild_cpu_model cpu (.sys_clk(sys_clk), .avs_read(avs_read), .avs_write(avs_write),
		.avs_address(avs_address), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Bus access; a missing answer ends the run
	task automatic acc(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
		bit ok;
		cpu.xfer(wr, idx, wd, d, ok);
		if (!ok) begin
			errors++;
			$display("unexpected bus answer: expected 1 seen 0");
			tally_and_finish();
		end
	endtask

	// One-cycle conversion pulse on the selected channels, then let flags settle
	task automatic conv(input logic [1:0] sel, input logic ov, input logic un);
		@(posedge sys_clk);
		for (int i = 0; i < 2; i++)
			conv_in[i] <= '{valid: sel[i], value: v[i], ovf: ov, unf: un};
		@(posedge sys_clk);
		conv_in <= '0;
		repeat (3) @(posedge sys_clk);
	endtask

	// Expected {below, above} for one result, signed and strict
	function automatic logic [1:0] lim(input logic [15:0] x, input logic [15:0] h,
			input logic [15:0] l);
		return {$signed(x) < $signed(l), $signed(x) > $signed(h)};
	endfunction

	initial begin
		logic [1:0] e0;
		logic [1:0] e2;
		logic [2:0] c;
		void'($urandom(32'h6b4e34c6));
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'h1;
		// Reset values, an unmapped place, limits crossed while disabled
		acc(0, aild_pkg::IDX_CTRL, 0);
		check(d, 0, "ctrl");
		acc(0, aild_pkg::IDX_HI0, 0);
		check(d[15:0], 16'h7FFF, "hi0");
		acc(0, aild_pkg::IDX_LO2, 0);
		check(d[15:0], 16'h8000, "lo2");
		acc(0, 4'hF, 0);
		check(d, 0, "unmapped");
		acc(1, aild_pkg::IDX_HI0, 32'h100);
		v[0] = 16'h200;
		conv(2'h1, 0, 0);
		acc(0, aild_pkg::IDX_DETAIL, 0);
		check(d, 0, "detail off");
		check(limit_irq, 0, "limit_irq off");
		$display("test reset done");
		// Random results against random limits
		acc(1, aild_pkg::IDX_CTRL, 32'h2);
		repeat (24) begin
			acc(1, aild_pkg::IDX_ACK, 32'h3);
			for (int i = 0; i < 2; i++) begin
				hi[i] = 16'($urandom);
				lo[i] = 16'($urandom);
				v[i] = 16'($urandom);
				acc(1, 4'(aild_pkg::IDX_HI0 + 2 * i), {16'h0, hi[i]});
				acc(1, 4'(aild_pkg::IDX_LO0 + 2 * i), {16'h0, lo[i]});
			end
			conv(2'h3, 0, 0);
			e0 = lim(v[0], hi[0], lo[0]);
			e2 = lim(v[1], hi[1], lo[1]);
			acc(0, aild_pkg::IDX_DETAIL, 0);
			check(d, {22'h0, e2[1], e0[1], 6'h0, e2[0], e0[0]}, "detail");
			check(limit_irq, |{e0, e2}, "limit_irq");
			acc(0, aild_pkg::IDX_RES0, 0);
			check(d[15:0], v[0], "res0");
			acc(0, aild_pkg::IDX_RES2, 0);
			check(d[15:0], v[1], "res2");
			check({diag_irq, group_fault_lamp}, 0, "side effects");
		end
		$display("test limits done");
		// Same cause twice before the event is serviced
		acc(1, aild_pkg::IDX_ACK, 32'h3);
		acc(1, aild_pkg::IDX_HI0, 32'h10);
		acc(1, aild_pkg::IDX_LO2, 32'h10);
		v[0] = 16'h20;
		v[1] = 16'h8;
		conv(2'h3, 0, 0);
		acc(0, aild_pkg::IDX_DIAG, 0);
		check(d[30], 0, "lost early");
		conv(2'h3, 0, 0);
		acc(0, aild_pkg::IDX_DIAG, 0);
		check(d[30], 1, "lost");
		check(diag_irq, 1, "lost irq");
		$display("test lost done");
		// Overflow and underflow under every enable combination
		for (int k = 0; k < 8; k++) begin
			c = 3'(k);
			acc(1, aild_pkg::IDX_ACK, 32'h3);
			acc(1, aild_pkg::IDX_CTRL, {29'h0, c});
			v[0] = 16'($urandom);
			v[1] = 16'($urandom);
			conv(2'h1, 1, 0);
			conv(2'h2, 0, 1);
			acc(0, aild_pkg::IDX_RES0, 0);
			check(d[15:0], 16'h7FFF, "ovf code");
			acc(0, aild_pkg::IDX_RES2, 0);
			check(d[15:0], 16'h8000, "unf code");
			acc(0, aild_pkg::IDX_DETAIL, 0);
			check(d, 0, "detail ovf");
			acc(0, aild_pkg::IDX_DIAG, 0);
			check({d[3], d[0]}, {2{c[2]}}, "entries");
			check(diag_irq, c[0], "diag_irq");
			check(group_fault_lamp, c[2], "lamp");
		end
		$display("test range done");
		// Mid-run reset drops every enable and pending flag
		rst_n <= 1'h0;
		@(posedge sys_clk);
		rst_n <= 1'h1;
		acc(0, aild_pkg::IDX_CTRL, 0);
		check(d, 0, "ctrl after reset");
		check(diag_irq, 0, "diag_irq after reset");
		check(group_fault_lamp, 0, "lamp after reset");
		$display("test second reset done");
		// Missing supply lights the lamp with all enables off
		acc(1, aild_pkg::IDX_ACK, 32'h3);
		acc(1, aild_pkg::IDX_CTRL, 0);
		supply_missing <= 1'h1;
		repeat (6) @(posedge sys_clk);
		check(group_fault_lamp, 1, "lamp supply");
		acc(0, aild_pkg::IDX_DIAG, 0);
		check(d[aild_pkg::DIAG_SUPPLY], 1, "supply status");
		supply_missing <= 1'h0;
		repeat (6) @(posedge sys_clk);
		check(group_fault_lamp, 0, "lamp off");
		$display("test supply done");
		tally_and_finish();
	end
endmodule
